// [include/sabp_pkg.sv]
// Shared constants for the steering angle and backup power-mode receiver
package sabp_pkg;

	// ------------------------------------------------------------
	// Field widths
	// ------------------------------------------------------------
	localparam int ANGLE_W = 16;
	localparam int RATE_W  = 12;
	localparam int CENT_W  = 2;
	localparam int PMODE_W = 2;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [CENT_W-1:0]  CENT_UNKNOWN    = 2'h0;
	localparam logic [CENT_W-1:0]  CENT_ESTIMATED  = 2'h1;
	localparam logic [CENT_W-1:0]  CENT_CALIBRATED = 2'h2;
	localparam logic [PMODE_W-1:0] PMODE_OFF       = 2'h0;
	localparam logic [PMODE_W-1:0] PMODE_ACCESSORY = 2'h1;
	localparam logic [PMODE_W-1:0] PMODE_RUN       = 2'h2;
	localparam logic [PMODE_W-1:0] PMODE_CRANK     = 2'h3;
	localparam logic               ANGLE_VALID     = 1'b0;
	localparam logic               ANGLE_INVALID   = 1'b1;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_ANGLE   = 8'h00;
	localparam logic [7:0] REG_RATE    = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_THRESH  = 8'h0C;
	localparam logic [7:0] REG_FRAMES  = 8'h10;
	localparam int         ADDR_W      = 8;

	// Status register bit positions
	localparam int ST_VALID_BIT   = 0;
	localparam int ST_CENT_LSB    = 1;
	localparam int ST_EFF_LSB     = 3;
	localparam int ST_BKEN_BIT    = 5;
	localparam int ST_BKAV_BIT    = 6;
	localparam int ST_LOADC_BIT   = 7;
	localparam int ST_CRANK_BIT   = 8;

	// Reset value and AXI response codes
	localparam logic [RATE_W-1:0] THRESH_RESET = 12'h0_7FF;
	localparam logic [1:0]        RESP_OKAY    = 2'h0;
	localparam logic [1:0]        RESP_SLVERR  = 2'h2;

endpackage

// [hw/sabp_decode.sv]
// Per-frame field qualification: validity substitution and power-mode selection
`timescale 1ns/1ps
module sabp_decode
	import sabp_pkg::*;
(
	// Raw fields
	input  wire logic [ANGLE_W-1:0] raw_angle,
	input  wire logic [RATE_W-1:0]  raw_rate,
	input  wire logic               raw_invalid,
	input  wire logic [PMODE_W-1:0] raw_backup_mode,
	input  wire logic               raw_backup_en,
	input  wire logic               raw_backup_avail,
	input  wire logic [PMODE_W-1:0] raw_primary_mode,
	// Qualified fields
	output logic      [ANGLE_W-1:0] q_angle,
	output logic      [RATE_W-1:0]  q_rate,
	output logic      [PMODE_W-1:0] q_mode
);

	always_comb begin
		q_angle = (raw_invalid == ANGLE_INVALID) ? '0 : raw_angle;
		q_rate  = (raw_invalid == ANGLE_INVALID) ? '0 : raw_rate;
		// Backup value used only when both enabled and master available
		if (raw_backup_en && raw_backup_avail) begin
			q_mode = raw_backup_mode;
		end else begin
			q_mode = raw_primary_mode;
		end
	end

endmodule

// [hw/sabp_rx.sv]
// Receiver holding registers, starter decision and AXI4-Lite register access
// Function
// - Angle is 16-bit signed, one sixteenth degree per count.
// - Rate is 12-bit signed, 1 deg/s per count, compared against threshold.
// - Invalid validity forces passed-on angle to zero.
// - Invalid validity forces passed-on rate to zero.
// - Positive angle and rate mean counterclockwise rotation.
// - Backup mode 2 bits: off, accessory, run, crank request.
// - Backup mode ignored unless enable true and master available.
// - Engine stop follows hardwired run/crank input, never backup mode.
// - Backup enable true with master available makes starter logic use backup mode.
// - Otherwise starter logic uses the primary power-mode field.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module sabp_rx
	import sabp_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	// Received frame
	input  wire logic               frame_strobe,
	input  wire logic [ANGLE_W-1:0] rx_angle,
	input  wire logic               rx_invalid,
	input  wire logic [CENT_W-1:0]  rx_centering,
	input  wire logic [RATE_W-1:0]  rx_rate,
	input  wire logic [PMODE_W-1:0] rx_backup_mode,
	input  wire logic               rx_backup_en,
	input  wire logic               rx_backup_avail,
	input  wire logic [PMODE_W-1:0] rx_primary_mode,
	// Hardwired run/crank
	input  wire logic               run_crank_in,
	// Qualified outputs
	output logic      [ANGLE_W-1:0] angle_out,
	output logic      [RATE_W-1:0]  rate_out,
	output logic      [CENT_W-1:0]  centering_out,
	output logic      [PMODE_W-1:0] power_mode_out,
	output logic                    crank_request,
	output logic                    load_comp,
	output logic                    engine_stop,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic      [1:0]         s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic      [31:0]        s_axi_rdata,
	output logic      [1:0]         s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Qualification
	// ------------------------------------------------------------
	logic [ANGLE_W-1:0] q_angle;
	logic [RATE_W-1:0]  q_rate;
	logic [PMODE_W-1:0] q_mode;

	sabp_decode u_decode (
		.raw_angle        (rx_angle),
		.raw_rate         (rx_rate),
		.raw_invalid      (rx_invalid),
		.raw_backup_mode  (rx_backup_mode),
		.raw_backup_en    (rx_backup_en),
		.raw_backup_avail (rx_backup_avail),
		.raw_primary_mode (rx_primary_mode),
		.q_angle          (q_angle),
		.q_rate           (q_rate),
		.q_mode           (q_mode)
	);

	function automatic logic [RATE_W-1:0] abs_rate(input logic [RATE_W-1:0] v);
		abs_rate = v[RATE_W-1] ? RATE_W'(~v + 1'b1) : v;
	endfunction

	// ------------------------------------------------------------
	// Holding registers
	// ------------------------------------------------------------
	logic              invalid_h;
	logic              bk_en_h;
	logic              bk_av_h;
	logic [RATE_W-1:0] thresh;
	logic [31:0]       frame_count;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			angle_out      <= '0;
			rate_out       <= '0;
			centering_out  <= CENT_UNKNOWN;
			power_mode_out <= PMODE_OFF;
			invalid_h      <= ANGLE_VALID;
			bk_en_h        <= 1'b0;
			bk_av_h        <= 1'b0;
		end else if (frame_strobe) begin
			// Signed values pass unchanged; sign carries rotation sense
			angle_out      <= q_angle;
			rate_out       <= q_rate;
			centering_out  <= rx_centering;
			power_mode_out <= q_mode;
			invalid_h      <= rx_invalid;
			bk_en_h        <= rx_backup_en;
			bk_av_h        <= rx_backup_avail;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_count <= '0;
		end else if (frame_strobe) begin
			frame_count <= frame_count + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// Starter and load decisions
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crank_request <= 1'b0;
			load_comp     <= 1'b0;
			engine_stop   <= 1'b0;
		end else begin
			crank_request <= (power_mode_out == PMODE_CRANK);
			load_comp     <= (abs_rate(rate_out) > thresh);
			// Network mode changes never stop the engine
			engine_stop   <= !run_crank_in;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			thresh        <= THRESH_RESET;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				if (aw_addr == REG_THRESH) begin
					s_axi_bresp <= RESP_OKAY;
					if (w_strb[0]) thresh[7:0]  <= w_data[7:0];
					if (w_strb[1]) thresh[11:8] <= w_data[11:8];
				end else if (aw_addr == REG_ANGLE || aw_addr == REG_RATE ||
						aw_addr == REG_STATUS || aw_addr == REG_FRAMES) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	logic [31:0] status_word;

	always_comb begin
		status_word                           = '0;
		status_word[ST_VALID_BIT]             = invalid_h;
		status_word[ST_CENT_LSB +: CENT_W]    = centering_out;
		status_word[ST_EFF_LSB +: PMODE_W]    = power_mode_out;
		status_word[ST_BKEN_BIT]              = bk_en_h;
		status_word[ST_BKAV_BIT]              = bk_av_h;
		status_word[ST_LOADC_BIT]             = load_comp;
		status_word[ST_CRANK_BIT]             = crank_request;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					REG_ANGLE:  s_axi_rdata <= {{16{angle_out[ANGLE_W-1]}}, angle_out};
					REG_RATE:   s_axi_rdata <= {{20{rate_out[RATE_W-1]}}, rate_out};
					REG_STATUS: s_axi_rdata <= status_word;
					REG_THRESH: s_axi_rdata <= {20'h0_0000, thresh};
					REG_FRAMES: s_axi_rdata <= frame_count;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// [testbench/sabp_chassis_model.sv]
// Chassis controller model that sends steering and backup power-mode frames
`timescale 1ns/1ps
module sabp_chassis_model
	import sabp_pkg::*;
(
	// Commands from the bench
	input  wire logic        send,
	input  wire logic [15:0] p_ang,
	input  wire logic [11:0] p_rate,
	input  wire logic [8:0]  p_f,
	// Frame to the receiver
	output logic             frame_strobe,
	output logic [15:0]      rx_angle,
	output logic             rx_invalid,
	output logic [1:0]       rx_centering,
	output logic [11:0]      rx_rate,
	output logic [1:0]       rx_backup_mode,
	output logic             rx_backup_en,
	output logic             rx_backup_avail,
	output logic [1:0]       rx_primary_mode
);
	// p_f: fail, learned, inferred, master fitted, available, backup, primary
	logic [1:0] cent;
	logic [1:0] bm;
	assign cent = p_f[7] ? CENT_CALIBRATED : (p_f[6] ? CENT_ESTIMATED : CENT_UNKNOWN);
	assign bm = p_f[5] ? p_f[3:2] : PMODE_OFF;
	// Fields are inverted between frames so a stale latch shows up
	assign frame_strobe = send;
	assign rx_angle = send ? p_ang : ~p_ang;
	assign rx_rate = send ? p_rate : ~p_rate;
	assign rx_invalid = send ? p_f[8] : ~p_f[8];
	assign rx_centering = send ? cent : ~cent;
	assign rx_backup_mode = send ? bm : ~bm;
	assign rx_backup_en = send ? p_f[5] : ~p_f[5];
	assign rx_backup_avail = send ? p_f[4] : ~p_f[4];
	assign rx_primary_mode = send ? p_f[1:0] : ~p_f[1:0];
endmodule

// [testbench/sabp_rx_assertions.sv]
// Checker for the receiver's frame qualification and engine stop
`timescale 1ns/1ps
module sabp_rx_assertions
	import sabp_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        frame_strobe,
	input wire logic [15:0] rx_angle,
	input wire logic        rx_invalid,
	input wire logic [1:0]  rx_centering,
	input wire logic [11:0] rx_rate,
	input wire logic [1:0]  rx_backup_mode,
	input wire logic        rx_backup_en,
	input wire logic        rx_backup_avail,
	input wire logic [1:0]  rx_primary_mode,
	input wire logic        run_crank_in,
	input wire logic [15:0] angle_out,
	input wire logic [11:0] rate_out,
	input wire logic [1:0]  centering_out,
	input wire logic [1:0]  power_mode_out,
	input wire logic        crank_request,
	input wire logic        engine_stop
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_bad; frame_strobe && rx_invalid; endsequence
	sequence s_good; frame_strobe && !rx_invalid; endsequence
	sequence s_bk; frame_strobe && rx_backup_en && rx_backup_avail; endsequence
	property p_ang0; s_bad |=> angle_out == 16'h0000; endproperty
	property p_rate0; s_bad |=> rate_out == 12'h000; endproperty
	property p_ang; s_good |=> angle_out == $past(rx_angle); endproperty
	property p_rate; s_good |=> rate_out == $past(rx_rate); endproperty
	property p_cent; frame_strobe |=> centering_out == $past(rx_centering); endproperty
	property p_bk; s_bk |=> power_mode_out == $past(rx_backup_mode); endproperty
	property p_pri; frame_strobe && !(rx_backup_en && rx_backup_avail) |=> power_mode_out == $past(rx_primary_mode);
	endproperty
	property p_hold; !frame_strobe |=> $stable(angle_out) && $stable(power_mode_out); endproperty
	property p_stop; 1'b1 |=> engine_stop == !$past(run_crank_in); endproperty
	property p_crank; 1'b1 |=> crank_request == ($past(power_mode_out) == PMODE_CRANK); endproperty
	a_ang0: assert property (p_ang0) else $error("angle not zeroed");
	a_rate0: assert property (p_rate0) else $error("rate not zeroed");
	a_ang: assert property (p_ang) else $error("angle not latched");
	a_rate: assert property (p_rate) else $error("rate not latched");
	a_cent: assert property (p_cent) else $error("centering wrong");
	a_bk: assert property (p_bk) else $error("backup mode not used");
	a_pri: assert property (p_pri) else $error("primary mode not used");
	a_hold: assert property (p_hold) else $error("held field moved");
	a_stop: assert property (p_stop) else $error("engine stop wrong");
	a_crank: assert property (p_crank) else $error("crank request wrong");
endmodule
bind sabp_rx sabp_rx_assertions u_sabp_rx_assertions (.*);

// [testbench/steer_angle_backup_power_rx_test.sv]
// Self-checking bench for the steering and backup power-mode receiver
`timescale 1ns/1ps
module steer_angle_backup_power_rx_test;
	import sabp_pkg::*;
	typedef struct packed {
		logic [15:0] a;
		logic [11:0] r;
		logic [8:0]  f;
		logic [15:0] ea;
		logic [11:0] er;
		logic [1:0]  ec;
		logic [1:0]  em;
		logic        el;
	} sabp_row_t;
	logic core_clk = 0, rst_b = 0, run_crank_in = 1, send = 0;
	logic [15:0] p_ang = 0;
	logic [11:0] p_rate = 0;
	logic [8:0] p_f = 0;
	logic frame_strobe, rx_invalid, rx_backup_en, rx_backup_avail;
	logic [15:0] rx_angle, angle_out;
	logic [11:0] rx_rate, rate_out;
	logic [1:0] rx_centering, rx_backup_mode, rx_primary_mode, centering_out, power_mode_out;
	logic crank_request, load_comp, engine_stop;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_count = 0, cmp_count = 0;
	sabp_row_t rows[6] = '{
		'{16'h0010, 12'h005, 9'h08E, 16'h0010, 12'h005, 2'h2, 2'h2, 1'b0},
		'{16'h8000, 12'h800, 9'h07C, 16'h8000, 12'h800, 2'h1, 2'h3, 1'b1},
		'{16'h7FFF, 12'h7FF, 9'h1A9, 16'h0000, 12'h000, 2'h2, 2'h1, 1'b0},
		'{16'hFFF0, 12'hFFF, 9'h037, 16'hFFF0, 12'hFFF, 2'h0, 2'h1, 1'b0},
		'{16'h1234, 12'h123, 9'h038, 16'h1234, 12'h123, 2'h0, 2'h2, 1'b0},
		'{16'h0ABC, 12'h0AB, 9'h032, 16'h0ABC, 12'h0AB, 2'h0, 2'h0, 1'b0}};
	sabp_rx u_sabp_rx (.*);
	sabp_chassis_model u_sabp_chassis_model (.*);
	always #12.5 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic run_row(input sabp_row_t w);
		@(posedge core_clk);
		{p_ang, p_rate, p_f, send} <= {w.a, w.r, w.f, 1'b1};
		@(posedge core_clk);
		send <= 0;
		@(posedge core_clk);
		#1;
		chk({16'h0000, angle_out}, {16'h0000, w.ea});
		chk({20'h0_0000, rate_out}, {20'h0_0000, w.er});
		chk({30'h0, centering_out}, {30'h0, w.ec});
		chk({30'h0, power_mode_out}, {30'h0, w.em});
		chk({31'h0, crank_request}, {31'h0, w.em == PMODE_CRANK});
		chk({31'h0, load_comp}, {31'h0, w.el});
		chk({31'h0, engine_stop}, 32'h0000_0000);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge core_clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic end_sim;
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		err_count++;
		end_sim;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		repeat (3) @(posedge core_clk);
		#1;
		chk({14'h0, angle_out, centering_out}, 32'h0000_0000);
		axr(REG_THRESH, 32'h0000_07FF, RESP_OKAY);
		foreach (rows[i]) run_row(rows[i]);
		axr(REG_STATUS, 32'h0000_0060, RESP_OKAY);
		run_row('{16'h1234, 12'h456, 9'h1FF, 16'h0000, 12'h000, 2'h2, 2'h3, 1'b0});
		axr(REG_STATUS, 32'h0000_017D, RESP_OKAY);
		// Strict compare at the threshold itself
		axw(REG_THRESH, 32'h0000_0005, RESP_OKAY);
		run_row('{16'hFF00, 12'hFFA, 9'h000, 16'hFF00, 12'hFFA, 2'h0, 2'h0, 1'b1});
		axr(REG_ANGLE, 32'hFFFF_FF00, RESP_OKAY);
		axr(REG_RATE, 32'hFFFF_FFFA, RESP_OKAY);
		run_row('{16'h0001, 12'h005, 9'h0A2, 16'h0001, 12'h005, 2'h2, 2'h2, 1'b0});
		axw(8'h40, 32'h0000_0001, RESP_SLVERR);
		axr(8'h40, 32'h0000_0000, RESP_SLVERR);
		axw(REG_FRAMES, 32'h0000_0000, RESP_OKAY);
		axr(REG_FRAMES, 32'h0000_0009, RESP_OKAY);
		run_crank_in <= 0;
		repeat (2) @(posedge core_clk);
		#1;
		chk({31'h0, engine_stop}, 32'h0000_0001);
		@(posedge core_clk);
		run_crank_in <= 1;
		@(posedge core_clk);
		rst_b <= 0;
		@(posedge core_clk);
		#1;
		chk({angle_out, rate_out, centering_out, power_mode_out}, 32'h0000_0000);
		// Second release: held fields, crank, engine stop, threshold and frame count must come back to reset values
		@(posedge core_clk);
		rst_b <= 1;
		repeat (3) @(posedge core_clk);
		#1;
		chk({angle_out, rate_out, centering_out, power_mode_out}, 32'h0000_0000);
		chk({30'h0, crank_request, engine_stop}, 32'h0000_0000);
		axr(REG_THRESH, 32'h0000_07FF, RESP_OKAY);
		axr(REG_FRAMES, 32'h0000_0000, RESP_OKAY);
		end_sim;
	end
endmodule
